// [pkg/tsd_fault_regs.svh]
// Constants for the thermal shutdown and fault control block
`ifndef TSD_FAULT_REGS_SVH
`define TSD_FAULT_REGS_SVH
`define CELL_COUNT 12
`define TEN_CELLS 4'ha
`define TWELVE_CELLS 4'hc
`define FIRST_CELL 4'h1
`define CFG_DCH_RESET 12'h000
`define CFG_TEN_RESET 1'b0
`define CFG_CONV_RESET 1'b0
`define LINK_LOSS_MS 2000
`define CLK_HZ 20000000
`define MS_TICK_CYCLES (`CLK_HZ / 1000)
`endif

// [pkg/tsd_fault_pkg.sv]
// Types for the thermal shutdown and fault control block
package tsd_fault_pkg;
   typedef enum logic [1:0]
   {
      ST_ACTIVE = 2'b00,
      ST_STANDBY = 2'b01
   } op_state_t;
   typedef struct packed
   {
      logic [11:0] discharge;
      logic ten_cell_select;
      logic conv_enable;
   } cfg_t;
   typedef struct packed
   {
      logic all_cells;
      logic single_cell;
      logic [3:0] cell_index;
   } conv_req_t;
endpackage

// [logic/ms_tick.sv]
// Millisecond enable pulse divider
`timescale 1ns/1ns
module ms_tick #(
   parameter int CYCLES = 20000
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   output logic tick_out
);
   logic [31:0] cnt_ff;
   always_ff @(posedge mclk_in)
   begin
      if (rst_in || cnt_ff == 32'(CYCLES - 1))
      begin
         cnt_ff <= 32'h0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 32'h1;
      end
   end
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         tick_out <= 1'b0;
      end
      else
      begin
         tick_out <= (cnt_ff == 32'(CYCLES - 1));
      end
   end
endmodule

// [logic/tsd_fault_ctrl.sv]
// Thermal shutdown, standby and discharge control
`timescale 1ns/1ns
`include "tsd_fault_regs.svh"
module tsd_fault_ctrl #(
   parameter int LINK_LOSS_MS = `LINK_LOSS_MS,
   parameter int MS_CYCLES = `MS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Configuration writes, commands and requests from the serial side
   input wire logic cfg_wr_in,
   input tsd_fault_pkg::cfg_t cfg_in,
   input wire logic rd_temp_cmd_in,
   input wire logic poll_req_in,
   input tsd_fault_pkg::conv_req_t conv_in,
   input wire logic [11:0] tied_top_in,
   // Pins from outside the clock domain
   input wire logic over_temp_in,
   input wire logic link_alive_in,
   input wire logic cur_port_active_in,
   input wire logic upper_link_ok_in,
   // Outputs
   output tsd_fault_pkg::cfg_t cfg_out,
   output logic [11:0] discharge_out,
   output logic [11:0] discharge_oe_out,
   output logic thermal_shutdown_flag_out,
   output logic watchdog_timeout_n_out,
   output logic tsd_detect_en_out,
   output logic conv_start_out,
   output logic [3:0] conv_first_out,
   output logic [3:0] conv_last_out,
   output logic [11:0] zero_result_out,
   output logic poll_en_out
);
   import tsd_fault_pkg::*;

   logic [3:0] s1_ff;
   logic [3:0] s2_ff;
   logic ot_s;
   logic link_s;
   logic cur_s;
   logic up_s;
   logic tick;
   logic [31:0] loss_ff;
   op_state_t state_ff;
   op_state_t nxt_state;
   cfg_t cfg_ff;
   logic detect_en;
   logic trip;

   // Two-stage synchronisers
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         s1_ff <= 4'h0;
         s2_ff <= 4'h0;
      end
      else
      begin
         s1_ff <= {upper_link_ok_in, cur_port_active_in, link_alive_in,
                   over_temp_in};
         s2_ff <= s1_ff;
      end
   end
   assign ot_s = s2_ff[0];
   assign link_s = s2_ff[1];
   assign cur_s = s2_ff[2];
   assign up_s = s2_ff[3];

   ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .tick_out(tick)
   );

   // Link loss timer in milliseconds
   always_ff @(posedge mclk_in)
   begin
      if (rst_in || link_s)
      begin
         loss_ff <= 32'h0;
      end
      else if (tick && loss_ff < 32'(LINK_LOSS_MS))
      begin
         loss_ff <= loss_ff + 32'h1;
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_ACTIVE:
         begin
            if (loss_ff == 32'(LINK_LOSS_MS - 1) && tick && !link_s)
            begin
               nxt_state = ST_STANDBY;
            end
         end
         ST_STANDBY:
         begin
            if (link_s)
            begin
               nxt_state = ST_ACTIVE;
            end
         end
         default:
         begin
            nxt_state = ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         state_ff <= ST_ACTIVE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign detect_en = (state_ff != ST_STANDBY) || cur_s;
   assign trip = detect_en && ot_s;

   // Configuration store, reset on a trip (overtemperature while detection is enabled)
   always_ff @(posedge mclk_in)
   begin
      if (rst_in || trip)
      begin
         cfg_ff.discharge <= `CFG_DCH_RESET;
         cfg_ff.ten_cell_select <= `CFG_TEN_RESET;
         cfg_ff.conv_enable <= `CFG_CONV_RESET;
      end
      else if (cfg_wr_in)
      begin
         cfg_ff <= cfg_in;
      end
   end

   // Sticky shutdown flag; a trip wins over the read clear
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         thermal_shutdown_flag_out <= 1'b0;
      end
      else if (trip)
      begin
         thermal_shutdown_flag_out <= 1'b1;
      end
      else if (rd_temp_cmd_in)
      begin
         thermal_shutdown_flag_out <= 1'b0;
      end
   end

   // Registered outputs
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         cfg_out <= '0;
         discharge_out <= 12'h000;
         discharge_oe_out <= 12'h000;
         watchdog_timeout_n_out <= 1'b1;
         tsd_detect_en_out <= 1'b1;
         poll_en_out <= 1'b0;
      end
      else
      begin
         cfg_out <= cfg_ff;
         // Pulled high when a switch is on; off in standby
         discharge_out <= (nxt_state == ST_STANDBY || trip) ? 12'h000
                          : cfg_ff.discharge;
         discharge_oe_out <= 12'hfff;
         watchdog_timeout_n_out <= (nxt_state != ST_STANDBY);
         tsd_detect_en_out <= detect_en;
         poll_en_out <= poll_req_in && up_s;
      end
   end

   // Conversion request decode
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         conv_start_out <= 1'b0;
         conv_first_out <= 4'h0;
         conv_last_out <= 4'h0;
         zero_result_out <= 12'h000;
      end
      else
      begin
         conv_start_out <= cfg_ff.conv_enable && !trip
                           && (conv_in.all_cells || conv_in.single_cell);
         if (conv_in.single_cell)
         begin
            conv_first_out <= conv_in.cell_index;
            conv_last_out <= conv_in.cell_index;
         end
         else if (conv_in.all_cells)
         begin
            conv_first_out <= `FIRST_CELL;
            conv_last_out <= cfg_ff.ten_cell_select ? `TEN_CELLS
                             : `TWELVE_CELLS;
         end
         zero_result_out <= tied_top_in;
      end
   end

   a_flag_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      trip |=> thermal_shutdown_flag_out)
      else $error("flag not set on trip");
   a_flag_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      rd_temp_cmd_in && !trip |=> !thermal_shutdown_flag_out)
      else $error("flag not cleared");
   a_flag_holds: assert property (@(posedge mclk_in) disable iff (rst_in)
      thermal_shutdown_flag_out && !rd_temp_cmd_in
      |=> thermal_shutdown_flag_out)
      else $error("flag dropped");
   a_cfg_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
      trip |=> cfg_ff.discharge == 12'h000 && !cfg_ff.conv_enable)
      else $error("config not reset");
   a_standby_off: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_ff == ST_STANDBY |-> discharge_out == 12'h000)
      else $error("discharge on in standby");
   a_wdt_low: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_ff == ST_STANDBY |-> !watchdog_timeout_n_out)
      else $error("watchdog not low");
   a_detect_en: assert property (@(posedge mclk_in) disable iff (rst_in)
      state_ff == ST_ACTIVE |=> tsd_detect_en_out)
      else $error("detect off");
   a_detect_cur: assert property (@(posedge mclk_in) disable iff (rst_in)
      cur_s |=> tsd_detect_en_out)
      else $error("detect off with current");
   a_ten_cells: assert property (@(posedge mclk_in) disable iff (rst_in)
      conv_in.all_cells && !conv_in.single_cell && cfg_ff.ten_cell_select
      |=> conv_last_out == `TEN_CELLS)
      else $error("ten cell range");
   a_poll_off: assert property (@(posedge mclk_in) disable iff (rst_in)
      !up_s |=> !poll_en_out)
      else $error("poll while link broken");
endmodule

// [dv/host_model.sv]
// Host side model: configuration writes, temperature reads, link
`timescale 1ns/1ns
module host_model (
   // Clock
   input wire logic mclk_in,
   // Serial side requests and the link alive pin
   output logic cfg_wr_out,
   output tsd_fault_pkg::cfg_t cfg_out,
   output logic rd_temp_cmd_out,
   output logic link_alive_out
);
   import tsd_fault_pkg::*;
   initial
   begin
      cfg_wr_out = 1'b0;
      cfg_out = '0;
      rd_temp_cmd_out = 1'b0;
      link_alive_out = 1'b1;
   end
   // One-cycle write, data inverted once released
   task automatic write_cfg(input cfg_t c);
      @(negedge mclk_in);
      cfg_wr_out = 1'b1;
      cfg_out = c;
      @(negedge mclk_in);
      cfg_wr_out = 1'b0;
      cfg_out = ~c;
   endtask
   // Temperature group read, a one-cycle read command pulse
   task automatic read_temp;
      @(negedge mclk_in);
      rd_temp_cmd_out = 1'b1;
      @(negedge mclk_in);
      rd_temp_cmd_out = 1'b0;
   endtask
   task automatic set_link(input logic v);
      link_alive_out = v;
   endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the thermal shutdown control block
`timescale 1ns/1ns
module tb_top;
   import tsd_fault_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic poll_req_in = 1'b0;
   logic over_temp_in = 1'b0;
   logic cur_port_active_in = 1'b0;
   logic upper_link_ok_in = 1'b1;
   conv_req_t conv_in = '0;
   logic [11:0] tied_top_in = 12'he00;
   logic cfg_wr, rd_temp, link_alive, flag, wdt_n, det_en, c_start, poll_en;
   cfg_t cfg_h, cfg_q;
   logic [11:0] dis, oe, zero;
   logic [3:0] c_first, c_last;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   initial forever #25 mclk_in = ~mclk_in;
   host_model host_u (.mclk_in(mclk_in), .cfg_wr_out(cfg_wr),
      .cfg_out(cfg_h), .rd_temp_cmd_out(rd_temp),
      .link_alive_out(link_alive));
   tsd_fault_ctrl #(.LINK_LOSS_MS(3), .MS_CYCLES(10)) dut_u (
      .mclk_in(mclk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr),
      .cfg_in(cfg_h), .rd_temp_cmd_in(rd_temp), .poll_req_in(poll_req_in),
      .conv_in(conv_in), .tied_top_in(tied_top_in),
      .over_temp_in(over_temp_in), .link_alive_in(link_alive),
      .cur_port_active_in(cur_port_active_in),
      .upper_link_ok_in(upper_link_ok_in), .cfg_out(cfg_q),
      .discharge_out(dis), .discharge_oe_out(oe),
      .thermal_shutdown_flag_out(flag), .watchdog_timeout_n_out(wdt_n),
      .tsd_detect_en_out(det_en), .conv_start_out(c_start),
      .conv_first_out(c_first), .conv_last_out(c_last),
      .zero_result_out(zero), .poll_en_out(poll_en));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic t_conv(input conv_req_t r, input logic [3:0] f, l,
      input logic s);
      logic st;
      st = 1'b0;
      conv_in = r;
      @(negedge mclk_in);
      conv_in = '0;
      repeat (3)
      begin
         st = st | c_start;
         @(negedge mclk_in);
      end
      chk("start", 16'(s), 16'(st));
      if (s)
      begin
         chk("first", 16'(f), 16'(c_first));
         chk("last", 16'(l), 16'(c_last));
      end
      chk("zero", 16'(tied_top_in), 16'(zero));
   endtask
   task automatic t_cfg;
      host_u.write_cfg({12'ha5c, 1'b1, 1'b1});
      wait_n(3);
      chk("cfg", 16'h2973, 16'(cfg_q));
      chk("dis", 16'ha5c, 16'(dis));
      chk("oe", 16'hfff, 16'(oe));
      t_conv('{1'b1, 1'b0, 4'h0}, 4'h1, 4'ha, 1'b1);
      t_conv('{1'b0, 1'b1, 4'h5}, 4'h5, 4'h5, 1'b1);
      host_u.write_cfg({12'ha5c, 1'b0, 1'b1});
      tied_top_in = 12'hc00;
      t_conv('{1'b1, 1'b0, 4'h0}, 4'h1, 4'hc, 1'b1);
   endtask
   task automatic t_trip;
      over_temp_in = 1'b1;
      wait_n(4);
      chk("flag", 16'h1, 16'(flag));
      chk("cfg_rst", 16'h0, 16'(cfg_q));
      chk("dis_rst", 16'h0, 16'(dis));
      host_u.read_temp();
      wait_n(1);
      chk("set_wins", 16'h1, 16'(flag));
      over_temp_in = 1'b0;
      wait_n(4);
      chk("hold", 16'h1, 16'(flag));
      t_conv('{1'b1, 1'b0, 4'h0}, 4'h1, 4'hc, 1'b0);
      host_u.read_temp();
      wait_n(1);
      chk("clr", 16'h0, 16'(flag));
   endtask
   task automatic t_link;
      int n;
      n = 0;
      host_u.write_cfg({12'h0ff, 1'b0, 1'b1});
      host_u.set_link(1'b0);
      while (wdt_n === 1'b1 && n < 60)
      begin
         @(negedge mclk_in);
         n++;
      end
      chk("wdt", 16'h0, 16'(wdt_n));
      chk("delay", 16'h1, 16'(n >= 20 && n <= 40));
      chk("sdis", 16'h0, 16'(dis));
      wait_n(1);
      chk("den", 16'h0, 16'(det_en));
      over_temp_in = 1'b1;
      wait_n(6);
      chk("noflag", 16'h0, 16'(flag));
      cur_port_active_in = 1'b1;
      wait_n(6);
      chk("den_cur", 16'h1, 16'(det_en));
      chk("flag_cur", 16'h1, 16'(flag));
      over_temp_in = 1'b0;
      cur_port_active_in = 1'b0;
      host_u.set_link(1'b1);
      wait_n(3);
      host_u.read_temp();
      wait_n(4);
      chk("wake", 16'h1, 16'(wdt_n));
      chk("clr_sb", 16'h0, 16'(flag));
   endtask
   task automatic t_poll;
      poll_req_in = 1'b1;
      wait_n(4);
      chk("poll", 16'h1, 16'(poll_en));
      upper_link_ok_in = 1'b0;
      wait_n(4);
      chk("poll_off", 16'h0, 16'(poll_en));
      chk("alive", 16'h1, 16'(wdt_n));
      upper_link_ok_in = 1'b1;
   endtask
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   initial
   begin
      wait_n(20);
      rst_in = 1'b0;
      wait_n(1);
      chk("wdt0", 16'h1, 16'(wdt_n));
      chk("den0", 16'h1, 16'(det_en));
      t_cfg();
      t_trip();
      t_link();
      t_poll();
      finish_test();
   end
endmodule
